// ---- hw/asr_ctrl.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Host controller driving an asynchronous static RAM over its pins
// Assumes: One request at a time; req is only honoured while ready is high
// Notes:   Read data pins pass a two-stage synchroniser before capture
//
// Functional notes
// [R1] - Write only while select and write enable low
// [R2] - One lane writes a byte, both a word
// [R3] - Memory ends write at first select/enable rise
// [R4] - Width select low: memory ignores byte lanes
// [R5] - Lane release ends write only when width high
// [R6] - Memory drives only when selected and reading
// [R7] - Read data valid within output enable access
// [R8] - Address valid long enough before write end
// [R9] - Select held low long enough before end
// [R10] - Write pulse meets its least width
// [R11] - Write data valid long enough before end
// [R12] - Used lanes active long enough before end
// [R13] - Memory floats outputs soon after write enable
// [R14] - Memory stays quiet briefly after write end
// [R15] - Released lanes float within their limit
// [R16] - No data drive until memory has floated
//////////////////////////////////////////////////////////////////////////////
module asr_ctrl #(
  parameter int ADDR_W = asr_pkg::ADDR_W,
  parameter int DATA_W = asr_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lanes,
  input  wire logic              req_word_mode,
  output logic                   ready,
  output logic [DATA_W-1:0]      rdata,
  output logic                   rdata_valid,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   sram_select_low_active,
  output logic                   sram_select_high_active,
  output logic                   mem_oe_n,
  output logic                   mem_we_n,
  output logic                   upper_byte_lane_n,
  output logic                   lower_byte_lane_n,
  output logic                   word_width_select,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe
);

  localparam int TW = 4;

  initial begin
    if (DATA_W != 16) $error("asr_ctrl serves a 16-bit data path only");
    if (asr_pkg::READ_ACCESS_CYC + asr_pkg::SYNC_DEPTH - 1 >= 2 ** TW) begin
      $error("asr_ctrl timer too narrow");
    end
    if (asr_pkg::FLOAT_CYC >= 2 ** TW) $error("asr_ctrl timer too narrow");
    if (asr_pkg::WRITE_PULSE_CYC >= 2 ** TW) $error("asr_ctrl timer too narrow");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= dq_i;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase timer
  logic          tmr_load;
  logic [TW-1:0] tmr_val;
  logic          tmr_done;

  asr_timer #(.W(TW)) u_timer (
    .clk      (clk),
    .rstn     (rstn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  asr_pkg::asr_state_t state_reg, state_next;
  logic [ADDR_W-1:0]   addr_reg, addr_next;
  logic [DATA_W-1:0]   dq_o_reg, dq_o_next;
  logic [DATA_W-1:0]   rdata_reg, rdata_next;
  logic [1:0]          lanes_n_reg, lanes_n_next;
  logic                dq_oe_reg, dq_oe_next;
  logic                sel_n_reg, sel_n_next;
  logic                sel_hi_reg, sel_hi_next;
  logic                oe_n_reg, oe_n_next;
  logic                we_n_reg, we_n_next;
  logic                width_reg, width_next;
  logic                ready_reg, ready_next;
  logic                rvalid_reg, rvalid_next;

  always_comb begin
    state_next   = state_reg;
    addr_next    = addr_reg;
    dq_o_next    = dq_o_reg;
    rdata_next   = rdata_reg;
    lanes_n_next = lanes_n_reg;
    dq_oe_next   = dq_oe_reg;
    sel_n_next   = sel_n_reg;
    sel_hi_next  = sel_hi_reg;
    oe_n_next    = oe_n_reg;
    we_n_next    = we_n_reg;
    width_next   = width_reg;
    rvalid_next  = 1'b0;
    tmr_load     = 1'b0;
    tmr_val      = '0;
    unique case (state_reg)
      asr_pkg::ASR_IDLE: begin
        if (req) begin
          addr_next   = req_addr;
          width_next  = req_word_mode;
          sel_n_next  = 1'b0;
          sel_hi_next = 1'b1;
          // No lane asked for means a full word
          lanes_n_next = (req_lanes == 2'h0) ? 2'h0 : ~req_lanes; // [R2]
          if (req_write) begin
            dq_o_next  = req_wdata;
            dq_oe_next = 1'b1; // [R11]
            state_next = asr_pkg::ASR_WR_SETUP;
          end else begin
            oe_n_next  = 1'b0; // [R16]
            tmr_load   = 1'b1;
            tmr_val    = TW'(asr_pkg::READ_ACCESS_CYC + asr_pkg::SYNC_DEPTH - 1);
            state_next = asr_pkg::ASR_RD_ACCESS;
          end
        end
      end
      asr_pkg::ASR_WR_SETUP: begin
        // Select, lanes, address and data settle one cycle ahead of the pulse
        we_n_next  = 1'b0; // [R1] [R8] [R9] [R12]
        tmr_load   = 1'b1;
        tmr_val    = TW'(asr_pkg::WRITE_PULSE_CYC - 1);
        state_next = asr_pkg::ASR_WR_PULSE;
      end
      asr_pkg::ASR_WR_PULSE: begin
        if (tmr_done) begin
          // Write always ends on enable, never on lanes, whatever the width
          we_n_next  = 1'b1; // [R10] [R5]
          state_next = asr_pkg::ASR_WR_END;
        end
      end
      asr_pkg::ASR_WR_END: begin
        sel_n_next   = 1'b1;
        sel_hi_next  = 1'b0;
        lanes_n_next = asr_pkg::LANES_IDLE;
        dq_oe_next   = 1'b0;
        state_next   = asr_pkg::ASR_IDLE;
      end
      asr_pkg::ASR_RD_ACCESS: begin
        if (tmr_done) begin
          state_next = asr_pkg::ASR_RD_CAPTURE;
        end
      end
      asr_pkg::ASR_RD_CAPTURE: begin
        rdata_next   = dq_sync_reg;
        rvalid_next  = 1'b1;
        oe_n_next    = 1'b1;
        sel_n_next   = 1'b1;
        sel_hi_next  = 1'b0;
        lanes_n_next = asr_pkg::LANES_IDLE;
        // Memory may still drive for its float time after release
        tmr_load     = 1'b1; // [R16]
        tmr_val      = TW'(asr_pkg::FLOAT_CYC - 1);
        state_next   = asr_pkg::ASR_RD_FLOAT;
      end
      asr_pkg::ASR_RD_FLOAT: begin
        if (tmr_done) begin
          state_next = asr_pkg::ASR_IDLE; // [R16]
        end
      end
      default: begin
        state_next = asr_pkg::ASR_IDLE;
      end
    endcase
    ready_next = (state_next == asr_pkg::ASR_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= asr_pkg::ASR_IDLE;
      addr_reg    <= '0;
      dq_o_reg    <= '0;
      rdata_reg   <= '0;
      lanes_n_reg <= asr_pkg::LANES_IDLE;
      dq_oe_reg   <= 1'b0;
      sel_n_reg   <= 1'b1;
      sel_hi_reg  <= 1'b0;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      width_reg   <= 1'b1;
      ready_reg   <= 1'b1;
      rvalid_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      addr_reg    <= addr_next;
      dq_o_reg    <= dq_o_next;
      rdata_reg   <= rdata_next;
      lanes_n_reg <= lanes_n_next;
      dq_oe_reg   <= dq_oe_next;
      sel_n_reg   <= sel_n_next;
      sel_hi_reg  <= sel_hi_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      width_reg   <= width_next;
      ready_reg   <= ready_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  assign mem_addr                = addr_reg;
  assign sram_select_low_active  = sel_n_reg;
  assign sram_select_high_active = sel_hi_reg;
  assign mem_oe_n                = oe_n_reg;
  assign mem_we_n                = we_n_reg;
  assign upper_byte_lane_n       = lanes_n_reg[1];
  assign lower_byte_lane_n       = lanes_n_reg[0];
  assign word_width_select       = width_reg;
  assign dq_o                    = dq_o_reg;
  assign dq_oe                   = dq_oe_reg;
  assign rdata                   = rdata_reg;
  assign rdata_valid             = rvalid_reg;
  assign ready                   = ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_write_end;
    $rose(we_n_reg);
  endsequence

  sequence s_write_start;
    $fell(we_n_reg);
  endsequence

  chk_write_overlap: assert property (!we_n_reg |-> !sel_n_reg && sel_hi_reg) // [R1]
    else $error("write enable low without select");
  chk_lane_choice: assert property (!we_n_reg |-> lanes_n_reg != asr_pkg::LANES_IDLE) // [R2]
    else $error("write pulse with no byte lane");
  chk_lane_hold: assert property (s_write_end |-> lanes_n_reg == $past(lanes_n_reg, 2)
                                   && lanes_n_reg != asr_pkg::LANES_IDLE) // [R5] [R12]
    else $error("lanes changed before write end");
  chk_addr_setup: assert property (s_write_end |-> $stable(addr_reg)
                                   && addr_reg == $past(addr_reg, 2)) // [R8]
    else $error("address not held before write end");
  chk_select_low: assert property (s_write_end |-> !sel_n_reg && $past(!sel_n_reg, 2)) // [R9]
    else $error("select not low long enough");
  chk_pulse_width: assert property (s_write_start |-> !we_n_reg ##1 s_write_end) // [R10]
    else $error("write pulse width wrong");
  chk_data_setup: assert property (s_write_end |-> dq_oe_reg && $past(dq_oe_reg, 2)
                                   && $stable(dq_o_reg)) // [R11]
    else $error("write data not held before end");
  chk_bus_release: assert property ($rose(oe_n_reg) |-> !dq_oe_reg [*2]) // [R16]
    else $error("data driven before memory floated");
  chk_read_gate: assert property (!oe_n_reg |-> !dq_oe_reg && we_n_reg) // [R16]
    else $error("read overlaps drive or write");
  // Access wait plus synchroniser plus capture: result pulse four edges after enable
  chk_read_timing: assert property ($fell(oe_n_reg) |-> ##4 rdata_valid) // [R7] [R16]
    else $error("read result late or early");

endmodule : asr_ctrl

// ---- hw/asr_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the asynchronous static RAM port controller
// Assumes: 10 MHz system clock; the slower speed grade is honoured throughout
// Notes:   Cycle counts derive from the printed times and the clock period
//////////////////////////////////////////////////////////////////////////////
package asr_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int SYNC_DEPTH    = 2;

  // Least times; both grades are met by taking the slower figure
  localparam int WRITE_PULSE_WIDTH_NS    = 60;
  localparam int SELECT_TO_WRITE_END_NS  = 70;
  localparam int ADDRESS_TO_WRITE_END_NS = 70;
  localparam int DATA_TO_WRITE_END_NS    = 35;
  localparam int LANE_TO_WRITE_END_NS    = 70;
  // Longest device times the controller must wait out
  localparam int READ_ACCESS_NS          = 85;
  localparam int OUTPUT_ENABLE_ACCESS_NS = 45;
  localparam int WRITE_TO_OUTPUT_FLOAT_NS = 25;
  localparam int LANE_RELEASE_TO_FLOAT_NS = 25;
  localparam int OUTPUT_FLOAT_NS         = 25;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int WRITE_PULSE_CYC = cyc_up(WRITE_PULSE_WIDTH_NS);
  localparam int READ_ACCESS_CYC = cyc_up(READ_ACCESS_NS);
  localparam int FLOAT_CYC       = cyc_up(OUTPUT_FLOAT_NS);

  localparam logic [1:0] LANES_IDLE = 2'h3;

  typedef enum logic [2:0] {
    ASR_IDLE       = 3'h0,
    ASR_WR_SETUP   = 3'h1,
    ASR_WR_PULSE   = 3'h2,
    ASR_WR_END     = 3'h3,
    ASR_RD_ACCESS  = 3'h4,
    ASR_RD_CAPTURE = 3'h5,
    ASR_RD_FLOAT   = 3'h6
  } asr_state_t;

endpackage : asr_pkg

// ---- hw/asr_timer.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Loadable down-counter pacing the write pulse, read access and float phases of a memory cycle
// Assumes: load and value come from logic on the same clock
// Notes:   done is high while the count stands at zero
//////////////////////////////////////////////////////////////////////////////
module asr_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  initial begin
    if (W < 1) $error("asr_timer width must be at least one");
  end

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);

endmodule : asr_timer

// ---- bench/asr_sram_model.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Behavioural static RAM standing on the controller's memory pins
// Assumes: Slower grade delays; width select high means lanes are honoured
// Notes:   Floated lanes show inverted data so a stale value never passes
//////////////////////////////////////////////////////////////////////////////
module asr_sram_model (
  input  wire logic [17:0] addr,
  input  wire logic        sel_n,
  input  wire logic        sel_h,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        ub_n,
  input  wire logic        lb_n,
  input  wire logic        wid,
  input  wire logic [15:0] din,
  output logic [15:0]      dout,
  output logic             driving
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [0:262143];
  logic [17:0] wa;
  logic [15:0] wd;
  logic [15:0] rd;
  logic        wu;
  logic        wl;
  logic        wr_act;
  logic        rd_on;

  initial rd = 16'h0;
  initial driving = 1'b0;
  assign wr_act = !sel_n && sel_h && !we_n;
  assign rd_on  = !sel_n && sel_h && !oe_n && we_n;

  always @* if (wr_act) begin
    wa = addr;
    wd = din;
    wu = ub_n;
    wl = lb_n;
  end
  // Commit at the first rise of select or write enable
  always @(negedge wr_act) begin
    if (!wid || !wu) mem[wa][15:8] = wd[15:8];
    if (!wid || !wl) mem[wa][7:0] = wd[7:0];
  end
  // Drive late within the access limit, drop at once on release
  always @(rd_on) if (rd_on) driving <= #40 1'b1; else driving = 1'b0;
  always @* if (driving) rd = mem[addr];
  assign dout[15:8] = (driving && (!wid || !ub_n)) ? rd[15:8] : ~rd[15:8];
  assign dout[7:0]  = (driving && (!wid || !lb_n)) ? rd[7:0] : ~rd[7:0];
endmodule : asr_sram_model

// ---- bench/async_sram_read_write_port_test.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the static RAM port controller
// Assumes: One request at a time, started only while ready is high
// Notes:   Pin timing is judged in time units, not cycles
//////////////////////////////////////////////////////////////////////////////
module async_sram_read_write_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rstn, req, req_write, req_word_mode, ready, rdata_valid;
  logic [17:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rdata, dq_i, dq_o;
  logic [1:0]  req_lanes;
  logic        sram_select_low_active, sram_select_high_active, mem_oe_n, mem_we_n;
  logic        upper_byte_lane_n, lower_byte_lane_n, word_width_select, dq_oe, drv;
  logic        wsel_seen;
  time         t_sel, t_we, t_adr, t_dat, t_ln;
  int          error_cnt = 0;
  int          total_checks = 0;

  asr_ctrl dut_u (.clk(clk), .rstn(rstn), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .req_word_mode(req_word_mode), .ready(ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .mem_addr(mem_addr), .sram_select_low_active(sram_select_low_active),
    .sram_select_high_active(sram_select_high_active), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .upper_byte_lane_n(upper_byte_lane_n),
    .lower_byte_lane_n(lower_byte_lane_n), .word_width_select(word_width_select),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  asr_sram_model mdl_u (.addr(mem_addr), .sel_n(sram_select_low_active),
    .sel_h(sram_select_high_active), .oe_n(mem_oe_n), .we_n(mem_we_n),
    .ub_n(upper_byte_lane_n), .lb_n(lower_byte_lane_n), .wid(word_width_select),
    .din(dq_o), .dout(dq_i), .driving(drv));

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  //////////////////////////////////////////////////////////////////////////////
  // Pin timing watch
  always @(negedge sram_select_low_active) t_sel = $time;
  always @(mem_addr) t_adr = $time;
  always @(dq_o) t_dat = $time;
  always @(upper_byte_lane_n or lower_byte_lane_n) t_ln = $time;
  always @(negedge mem_we_n) begin
    t_we = $time;
    wsel_seen = word_width_select;
  end
  always @(posedge mem_we_n) if (sram_select_low_active === 1'b0) begin
    chk(sram_select_high_active, 1'b1, "high select in pulse");
    chk($time - t_sel >= 70, 1'b1, "select to end");
    chk($time - t_we >= 60, 1'b1, "pulse width");
    chk($time - t_adr >= 70, 1'b1, "address to end");
    chk($time - t_dat >= 35, 1'b1, "data to end");
    chk(!word_width_select || ($time - t_ln >= 70), 1'b1, "lane to end");
  end
  // A lane release must never be what ends a write
  always @(posedge upper_byte_lane_n or posedge lower_byte_lane_n)
    if (rstn === 1'b1) chk(mem_we_n, 1'b1, "lane release in pulse");
  always @(dq_oe or drv) if (dq_oe === 1'b1 && drv === 1'b1) chk(1'b0, 1'b1, "contention");

  //////////////////////////////////////////////////////////////////////////////
  // Request driver and scenarios
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
                    input logic [1:0] ln, input logic wm, output logic [15:0] got);
    int n;
    @(posedge clk);
    req           <= 1'b1;
    req_write     <= w;
    req_addr      <= a;
    req_wdata     <= d;
    req_lanes     <= ln;
    req_word_mode <= wm;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    got = 16'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (rdata_valid === 1'b1) got = rdata;
    end while (ready !== 1'b1 && n < 20);
    chk(n, w ? 3 : 5, "cycle length");
    if (w) chk(wsel_seen, wm, "width pin");
  endtask : op

  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln,
                    input logic wm);
    logic [15:0] unused;
    op(1'b1, a, d, ln, wm, unused);
  endtask : wr

  task automatic rd_chk(input logic [17:0] a, input logic [15:0] exp);
    logic [15:0] got;
    op(1'b0, a, 16'h0, 2'h3, 1'b1, got);
    chk(got, exp, "read back");
  endtask : rd_chk

  task automatic test_word();
    wr(18'h00123, 16'ha5c3, 2'h3, 1'b1);
    wr(18'h3ffff, 16'h0ff0, 2'h3, 1'b1);
    rd_chk(18'h00123, 16'ha5c3);
    rd_chk(18'h3ffff, 16'h0ff0);
  endtask : test_word

  task automatic test_bytes();
    wr(18'h00040, 16'h0000, 2'h3, 1'b1);
    wr(18'h00040, 16'hab99, 2'h2, 1'b1);
    rd_chk(18'h00040, 16'hab00);
    wr(18'h00040, 16'h7734, 2'h1, 1'b1);
    rd_chk(18'h00040, 16'hab34);
    wr(18'h00040, 16'h5555, 2'h0, 1'b1);
    rd_chk(18'h00040, 16'h5555);
  endtask : test_bytes

  task automatic test_width_low();
    wr(18'h01000, 16'h0000, 2'h3, 1'b1);
    wr(18'h01000, 16'h5aa5, 2'h1, 1'b0);
    rd_chk(18'h01000, 16'h5aa5);
  endtask : test_width_low

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial begin
    clk           = 1'b0;
    rstn          = 1'b0;
    req           = 1'b0;
    req_write     = 1'b0;
    req_addr      = 18'h0;
    req_wdata     = 16'h0;
    req_lanes     = 2'h3;
    req_word_mode = 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(ready, 1'b1, "reset ready");
    chk(sram_select_low_active, 1'b1, "reset select");
    chk(mem_we_n, 1'b1, "reset write enable");
    chk(dq_oe, 1'b0, "reset data enable");
    chk(mem_oe_n, 1'b1, "reset output enable");
    chk(sram_select_high_active, 1'b0, "reset high select");
    chk(word_width_select, 1'b1, "reset width select");
    chk(rdata_valid, 1'b0, "reset read valid");
    test_word();
    test_bytes();
    test_width_low();
    final_report();
  end

  // Whole run is near 93 cycles; this cuts a hang at 5000
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
endmodule : async_sram_read_write_port_test
